// >>> psi_pkg.sv
package psi_pkg;

  // management register addresses
  localparam logic [4:0] REG_SUMMARY = 5'h19;
  localparam logic [4:0] REG_IRQ = 5'h1a;
  localparam logic [4:0] REG_AUX2 = 5'h1b;

  // status summary bit positions
  localparam int SUM_AN_DONE = 15;
  localparam int SUM_CMPL_ACK = 14;
  localparam int SUM_ACK_DET = 13;
  localparam int SUM_ABILITY = 12;
  localparam int SUM_PAUSE = 11;
  localparam int SUM_MODE_HI = 10;
  localparam int SUM_MODE_LO = 8;
  localparam int SUM_PD_FAULT = 7;
  localparam int SUM_RFAULT = 6;
  localparam int SUM_PAGE = 5;
  localparam int SUM_LP_AN = 4;
  localparam int SUM_SPEED = 3;
  localparam int SUM_LINK = 2;
  localparam int SUM_AN_EN = 1;
  localparam int SUM_JABBER = 0;

  // interrupt register bit positions
  localparam int INT_RSV15 = 15;
  localparam int INT_ENABLE = 14;
  localparam int INT_MASK_HI = 11;
  localparam int INT_MASK_LO = 8;
  localparam int INT_FLAG_HI = 3;
  localparam int INT_FLAG_LO = 1;
  localparam int INT_STATUS = 0;
  localparam logic [3:0] INT_MASK_RESET = 4'hf;
  // mask/flag order inside the 3-bit groups: duplex, speed, link
  localparam int MSK_MASTER = 0;

  // auxiliary mode 2 layout
  localparam int AUX2_DRIBBLE = 11;
  localparam int AUX2_JUMBO = 10;
  localparam int AUX2_TXC_INV = 8;
  localparam int AUX2_ECHO_BLK = 7;
  localparam int AUX2_QUAL_PD = 1;
  localparam logic [15:0] AUX2_WR_MASK = 16'h0ffe;
  localparam logic [15:0] AUX2_RESET = 16'h008a;

  // negotiated mode encodings
  localparam logic [2:0] MODE_NONE = 3'h0;
  localparam logic [2:0] MODE_10HD = 3'h1;
  localparam logic [2:0] MODE_10FD = 3'h2;
  localparam logic [2:0] MODE_100HD = 3'h3;
  localparam logic [2:0] MODE_100T4 = 3'h4;
  localparam logic [2:0] MODE_100FD = 3'h5;

  // serial management frame
  localparam logic [5:0] MI_PREAMBLE_LEN = 6'h20;
  localparam logic [4:0] MI_HDR_LEN = 5'h0e;
  localparam logic [4:0] MI_DATA_LAST = 5'h0f;
  localparam logic [1:0] MI_START = 2'h1;
  localparam logic [1:0] MI_OP_READ = 2'h2;
  localparam logic [1:0] MI_OP_WRITE = 2'h1;
  localparam logic [1:0] NIBBLE_BITS = 2'h3;

  typedef struct packed {
    logic an_done;
    logic cmpl_ack_evt;
    logic ack_evt;
    logic ability_evt;
    logic pause;
    logic [2:0] resolved_best_mode;
    logic pd_fault_evt;
    logic remote_fault;
    logic page_evt;
    logic partner_an_able;
    logic jabber_evt;
  } psi_an_status_type;

  typedef struct packed {
    logic duplex_mode;
    logic link_rate;
    logic link_pass;
  } psi_line_type;

  typedef struct packed {
    logic dribble_correct_en;
    logic jumbo_en;
    logic txc_invert;
    logic echo_block_en;
    logic qual_pd_en;
  } psi_mode_type;

endpackage : psi_pkg

// >>> psi_status_regs.sv
`timescale 1ns/1ps
module psi_status_regs import psi_pkg::*; #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // management pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  // strap and control inputs
  input wire logic autoneg_strap_pin,
  input wire logic an_ctrl_en,
  // negotiation and line state
  input wire psi_an_status_type an_stat,
  input wire psi_line_type line_stat,
  // datapath hooks
  input wire logic tx_en,
  input wire logic rx_dv_raw,
  input wire logic crs_raw,
  input wire logic [15:0] rx_bit_len,
  input wire logic pd_detect,
  input wire logic pd_is_100,
  input wire logic adv_10,
  input wire logic adv_100,
  // outputs
  output logic irq_out_n,
  output psi_mode_type mode_cfg,
  output logic rx_dv,
  output logic crs,
  output logic [15:0] rx_nibble_len,
  output logic link_assert
);

  function automatic logic latch_one(input logic cur, input logic set, input logic clr);
    latch_one = set | (cur & ~clr);
  endfunction : latch_one

  typedef enum {MI_IDLE, MI_HEADER, MI_TURN, MI_DATA} psi_mi_state_type;

  // pin synchronisers and mdc edge detect
  logic mdc_s1, mdc_s2, mdc_prev, mdio_s1, mdio_s2, strap_s1, strap_s2;
  always_ff @(posedge core_clk) begin
    mdc_s1 <= mdc;
    mdc_s2 <= mdc_s1;
    mdc_prev <= mdc_s2;
    mdio_s1 <= mdio_in;
    mdio_s2 <= mdio_s1;
    strap_s1 <= autoneg_strap_pin;
    strap_s2 <= strap_s1;
  end
  wire logic mdc_rise = mdc_s2 & ~mdc_prev;

  // serial management engine
  psi_mi_state_type mi_state;
  logic [5:0] ones_cnt;
  logic [4:0] bit_cnt;
  logic [13:0] hdr;
  logic [15:0] shreg;
  logic is_read;
  logic rd_pulse;
  logic wr_pulse;
  logic [4:0] acc_reg;
  wire logic [13:0] next_hdr = {hdr[12:0], mdio_s2};
  logic [15:0] rd_value;

  always_ff @(posedge core_clk) begin
    rd_pulse <= 1'b0;
    wr_pulse <= 1'b0;
    if (reset) begin
      mi_state <= MI_IDLE;
      ones_cnt <= '0;
      bit_cnt <= '0;
      hdr <= '0;
      shreg <= '0;
      is_read <= 1'b0;
      acc_reg <= '0;
      mdio_out <= 1'b1;
      mdio_oe_n <= 1'b1;
    end else if (mdc_rise) begin
      unique case (mi_state)
        MI_IDLE: begin
          if (mdio_s2) begin
            if (ones_cnt != MI_PREAMBLE_LEN) ones_cnt <= ones_cnt + 6'h01;
          end else if (ones_cnt == MI_PREAMBLE_LEN) begin
            hdr <= '0;
            bit_cnt <= 5'h01;
            mi_state <= MI_HEADER;
          end else begin
            ones_cnt <= '0;
          end
        end
        MI_HEADER: begin
          hdr <= next_hdr;
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt + 5'h01 == MI_HDR_LEN) begin
            ones_cnt <= '0;
            bit_cnt <= '0;
            acc_reg <= next_hdr[4:0];
            if (next_hdr[13:12] != MI_START || next_hdr[9:5] != PHY_ADDR) begin
              mi_state <= MI_IDLE;
            end else if (next_hdr[11:10] == MI_OP_READ) begin
              // snapshot now: the clearing read happens here
              is_read <= 1'b1;
              shreg <= rd_value;
              rd_pulse <= 1'b1;
              mi_state <= MI_TURN;
            end else if (next_hdr[11:10] == MI_OP_WRITE) begin
              is_read <= 1'b0;
              mi_state <= MI_TURN;
            end else begin
              mi_state <= MI_IDLE;
            end
          end
        end
        MI_TURN: begin
          bit_cnt <= bit_cnt + 5'h01;
          if (is_read && bit_cnt == 5'h00) begin
            mdio_out <= 1'b0;
            mdio_oe_n <= 1'b0;
          end
          if (bit_cnt == 5'h01) begin
            bit_cnt <= '0;
            mi_state <= MI_DATA;
            if (is_read) begin
              mdio_out <= shreg[15];
              shreg <= {shreg[14:0], 1'b0};
            end
          end
        end
        MI_DATA: begin
          bit_cnt <= bit_cnt + 5'h01;
          if (is_read) begin
            mdio_out <= shreg[15];
            shreg <= {shreg[14:0], 1'b0};
          end else begin
            shreg <= {shreg[14:0], mdio_s2};
          end
          if (bit_cnt == MI_DATA_LAST) begin
            mdio_oe_n <= 1'b1;
            mdio_out <= 1'b1;
            wr_pulse <= ~is_read;
            mi_state <= MI_IDLE;
          end
        end
      endcase
    end
  end

  // clear on the snapshot edge itself, so an event one cycle later is never lost
  wire logic rd_take = mdc_rise && mi_state == MI_HEADER && bit_cnt + 5'h01 == MI_HDR_LEN &&
    next_hdr[13:12] == MI_START && next_hdr[9:5] == PHY_ADDR && next_hdr[11:10] == MI_OP_READ;
  wire logic rd_sum = rd_take && next_hdr[4:0] == REG_SUMMARY;
  wire logic rd_int = rd_take && next_hdr[4:0] == REG_IRQ;
  wire logic wr_int = wr_pulse && acc_reg == REG_IRQ;
  wire logic wr_aux2 = wr_pulse && acc_reg == REG_AUX2;

  // strap capture after reset release, and summary latches
  logic strap_taken, an_en_reset;
  logic hi_cmpl_ack, hi_ack, hi_ability, hi_pd_fault, hi_page, hi_jabber, lo_link;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      strap_taken <= 1'b0;
      an_en_reset <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      an_en_reset <= strap_s2;
    end
  end
  wire logic an_enabled = an_en_reset & an_ctrl_en;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      hi_cmpl_ack <= 1'b0;
      hi_ack <= 1'b0;
      hi_ability <= 1'b0;
      hi_pd_fault <= 1'b0;
      hi_page <= 1'b0;
      hi_jabber <= 1'b0;
      lo_link <= 1'b0;
    end else begin
      hi_cmpl_ack <= latch_one(hi_cmpl_ack, an_stat.cmpl_ack_evt, rd_sum);
      hi_ack <= latch_one(hi_ack, an_stat.ack_evt, rd_sum);
      hi_ability <= latch_one(hi_ability, an_stat.ability_evt, rd_sum);
      hi_pd_fault <= latch_one(hi_pd_fault, an_stat.pd_fault_evt, rd_sum);
      hi_page <= latch_one(hi_page, an_stat.page_evt, rd_sum);
      hi_jabber <= latch_one(hi_jabber, an_stat.jabber_evt, rd_sum);
      // loss wins over the reload that a read performs
      lo_link <= line_stat.link_pass & (lo_link | rd_sum);
    end
  end

  // interrupt register
  logic int_rsv15, int_enable;
  logic [3:0] int_mask;
  logic [2:0] chg_flag;
  logic int_stat;
  psi_line_type line_prev;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      int_rsv15 <= 1'b0;
      int_enable <= 1'b0;
      int_mask <= INT_MASK_RESET;
    end else if (wr_int) begin
      int_rsv15 <= shreg[INT_RSV15];
      int_enable <= shreg[INT_ENABLE];
      int_mask <= shreg[INT_MASK_HI:INT_MASK_LO];
    end
  end

  wire logic [2:0] line_chg = line_stat ^ line_prev;
  // masked events set no flag, so they raise neither pin nor status
  wire logic [2:0] chg_evt = line_chg & ~int_mask[3:1];
  wire logic [2:0] next_flag = chg_evt | (chg_flag & ~{3{rd_int}});
  wire logic irq_cond = int_enable & ~int_mask[MSK_MASTER] & |next_flag;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      // track the line during reset so release shows no false change
      line_prev <= line_stat;
      chg_flag <= '0;
      int_stat <= 1'b0;
    end else begin
      line_prev <= line_stat;
      chg_flag <= next_flag;
      int_stat <= latch_one(int_stat, irq_cond, rd_int);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) irq_out_n <= 1'b1;
    else irq_out_n <= ~irq_cond;
  end

  // auxiliary mode 2
  logic [15:0] aux2;
  always_ff @(posedge core_clk) begin
    if (reset) aux2 <= AUX2_RESET;
    // reserved bits inside AUX2_WR_MASK store what the manager writes; bits 15:12 and 0 are forced to zero
    else if (wr_aux2) aux2 <= shreg & AUX2_WR_MASK;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode_cfg <= '0;
    end else begin
      mode_cfg.dribble_correct_en <= aux2[AUX2_DRIBBLE];
      mode_cfg.jumbo_en <= aux2[AUX2_JUMBO];
      mode_cfg.txc_invert <= aux2[AUX2_TXC_INV];
      mode_cfg.echo_block_en <= aux2[AUX2_ECHO_BLK];
      mode_cfg.qual_pd_en <= aux2[AUX2_QUAL_PD];
    end
  end

  // read data multiplexer
  always_comb begin
    rd_value = '0;
    unique case (next_hdr[4:0])
      REG_SUMMARY: begin
        rd_value[SUM_AN_DONE] = an_stat.an_done;
        rd_value[SUM_CMPL_ACK] = hi_cmpl_ack;
        rd_value[SUM_ACK_DET] = hi_ack;
        rd_value[SUM_ABILITY] = hi_ability;
        rd_value[SUM_PAUSE] = an_stat.pause;
        rd_value[SUM_MODE_HI:SUM_MODE_LO] = an_stat.resolved_best_mode;
        rd_value[SUM_PD_FAULT] = hi_pd_fault;
        rd_value[SUM_RFAULT] = an_stat.remote_fault;
        rd_value[SUM_PAGE] = hi_page;
        rd_value[SUM_LP_AN] = an_stat.partner_an_able;
        rd_value[SUM_SPEED] = line_stat.link_rate;
        rd_value[SUM_LINK] = lo_link;
        rd_value[SUM_AN_EN] = an_enabled;
        rd_value[SUM_JABBER] = hi_jabber;
      end
      REG_IRQ: begin
        rd_value[INT_RSV15] = int_rsv15;
        rd_value[INT_ENABLE] = int_enable;
        rd_value[INT_MASK_HI:INT_MASK_LO] = int_mask;
        rd_value[INT_FLAG_HI:INT_FLAG_LO] = chg_flag;
        rd_value[INT_STATUS] = int_stat;
      end
      REG_AUX2: rd_value = aux2;
      default: rd_value = '0;
    endcase
  end

  // datapath hooks
  wire logic half_10 = ~line_stat.link_rate & ~line_stat.duplex_mode;
  wire logic pd_adv_ok = pd_is_100 ? adv_100 : adv_10;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_dv <= 1'b0;
      crs <= 1'b0;
      rx_nibble_len <= '0;
      link_assert <= 1'b0;
    end else begin
      rx_dv <= rx_dv_raw | (tx_en & half_10 & ~aux2[AUX2_ECHO_BLK]);
      crs <= crs_raw | (tx_en & half_10);
      rx_nibble_len <= aux2[AUX2_DRIBBLE] ? {rx_bit_len[15:2], ~NIBBLE_BITS & rx_bit_len[1:0]} : rx_bit_len;
      link_assert <= pd_detect & (~aux2[AUX2_QUAL_PD] | pd_adv_ok);
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_mode_reset: assert property ($fell(reset) |-> mode_cfg == '0
    ##1 mode_cfg.echo_block_en && mode_cfg.qual_pd_en)
    else $error("aux mode 2 reset values wrong");
  a_int_disable: assert property (!int_enable |=> irq_out_n)
    else $error("interrupt pin active while disabled");
  a_master_mask: assert property (int_mask[MSK_MASTER] |=> irq_out_n)
    else $error("interrupt pin active under master mask");
  a_duplex_mask: assert property (int_mask[3] && !chg_flag[2] && !$changed(int_mask) |=> !chg_flag[2])
    else $error("masked duplex change set its flag");
  a_pin_follows_flag: assert property (int_enable && !int_mask[MSK_MASTER] && chg_evt != 3'h0 |=> !irq_out_n)
    else $error("unmasked event did not drive pin");
  a_flag_hold: assert property (chg_flag[0] && !rd_int |=> chg_flag[0])
    else $error("link change flag lost without read");
  a_event_kept: assert property (rd_sum && an_stat.page_evt |=> hi_page)
    else $error("page event lost during read");
  a_link_low: assert property (!line_stat.link_pass |=> !lo_link ##1 (!lo_link || $past(rd_sum)))
    else $error("link loss not latched low");
  a_stat_clear: assert property (rd_int && !irq_cond |=> !int_stat)
    else $error("interrupt status not cleared by read");
  a_irq_release: assert property (rd_int && !(|chg_evt) && !irq_out_n |=> irq_out_n)
    else $error("interrupt pin held after clearing read");
  a_nibble_round: assert property (mode_cfg.dribble_correct_en && $stable(aux2) |=> rx_nibble_len[1:0] == 2'h0)
    else $error("dribble bits not rounded off");

  c_read_frame: cover property (rd_pulse);
  c_write_aux2: cover property (wr_aux2);
  c_irq_fire: cover property ($fell(irq_out_n));
  c_read_clears: cover property (rd_int ##1 irq_out_n);

endmodule : psi_status_regs

// >>> psi_mgmt_station.sv
`timescale 1ns/1ps
module psi_mgmt_station (
  // reference clock
  input wire logic core_clk,
  // management wire
  input wire logic mdio_line,
  output logic mdc,
  output logic sta_en,
  output logic sta_val
);
  int half = 10;
  logic ta_level = 1'b1;

  initial begin
    mdc = 1'b0;
    sta_en = 1'b0;
    sta_val = 1'b1;
  end

  // mdc idles low between frames; data changes only while mdc is low
  task automatic frame(input logic [4:0] phy, input logic [4:0] rg, input logic wr,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hffffffff, 2'b01, !wr, wr, phy, rg, 2'b10, wd};
    rd = 16'h0;
    for (int i = 63; i >= 0; i--) begin
      // let go of the line for turnaround and read data
      sta_en = wr || i > 17;
      sta_val = bits[i];
      repeat (half) @(negedge core_clk);
      mdc = 1'b1;
      repeat (half) @(negedge core_clk);
      if (i == 17) ta_level = mdio_line;
      if (!wr && i >= 1 && i <= 16) rd[i - 1] = mdio_line;
      mdc = 1'b0;
    end
    sta_en = 1'b0;
  endtask : frame
endmodule : psi_mgmt_station

// >>> psi_status_regs_tb_top.sv
`timescale 1ns/1ps
module psi_status_regs_tb_top;
  import psi_pkg::*;
  localparam logic [4:0] PHY = 5'h01;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic mdc, mdio_in, mdio_out, mdio_oe_n, sta_en, sta_val;
  logic strap = 1'b1;
  logic an_ctrl_en = 1'b1;
  psi_an_status_type an_stat = '0;
  psi_line_type line_stat = 3'b001;
  logic tx_en = 1'b0;
  logic rx_dv_raw = 1'b0;
  logic crs_raw = 1'b0;
  logic [15:0] rx_bit_len = 16'h0;
  logic [3:0] pd_in = 4'h0;
  logic irq_out_n, rx_dv, crs, link_assert;
  logic [15:0] rx_nibble_len;
  psi_mode_type mode_cfg;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] lfsr = 32'hd09d;
  // reference model state
  logic [15:0] hi_sum = 16'h0;
  logic lo_link = 1'b0;
  logic [15:0] ictl = 16'h0f00;
  logic [3:0] iflags = 4'h0;
  logic [15:0] aux2 = AUX2_RESET;
  logic [15:0] rd;
  int hi_pos[6] = '{14, 13, 12, 7, 5, 0};
  logic [15:0] aux_set[3] = '{16'h0d8a, 16'h0008, 16'h0008};

  // pull-up on the shared line when nobody drives it
  assign mdio_in = !mdio_oe_n ? mdio_out : (sta_en ? sta_val : 1'b1);

  always #4 core_clk = ~core_clk;

  psi_status_regs #(.PHY_ADDR(PHY)) u_dut (
    .core_clk(core_clk), .reset(reset), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n), .autoneg_strap_pin(strap), .an_ctrl_en(an_ctrl_en), .an_stat(an_stat),
    .line_stat(line_stat), .tx_en(tx_en), .rx_dv_raw(rx_dv_raw), .crs_raw(crs_raw),
    .rx_bit_len(rx_bit_len), .pd_detect(pd_in[3]), .pd_is_100(pd_in[2]), .adv_10(pd_in[1]),
    .adv_100(pd_in[0]), .irq_out_n(irq_out_n), .mode_cfg(mode_cfg), .rx_dv(rx_dv), .crs(crs),
    .rx_nibble_len(rx_nibble_len), .link_assert(link_assert)
  );

  psi_mgmt_station u_sta (
    .core_clk(core_clk), .mdio_line(mdio_in), .mdc(mdc), .sta_en(sta_en), .sta_val(sta_val)
  );

  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_step

  function automatic logic [15:0] exp_sum();
    logic [15:0] v;
    v = hi_sum;
    v[SUM_AN_DONE] = an_stat.an_done;
    v[SUM_PAUSE] = an_stat.pause;
    v[SUM_MODE_HI:SUM_MODE_LO] = an_stat.resolved_best_mode;
    v[SUM_RFAULT] = an_stat.remote_fault;
    v[SUM_LP_AN] = an_stat.partner_an_able;
    v[SUM_SPEED] = line_stat.link_rate;
    v[SUM_LINK] = lo_link;
    v[SUM_AN_EN] = strap & an_ctrl_en;
    return v;
  endfunction : exp_sum

  task automatic summarize();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
    checked++;
    if ((got & m) !== (exp & m)) begin
      n_fail++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic pin_chk();
    repeat (3) @(negedge core_clk);
    check({15'h0, irq_out_n}, {15'h0, !(ictl[INT_ENABLE] && !ictl[INT_MASK_LO] && |iflags[3:1])}, 16'h1);
  endtask : pin_chk

  task automatic wr(input logic [4:0] rg, input logic [15:0] d);
    u_sta.frame(PHY, rg, 1'b1, d, rd);
    if (rg == REG_IRQ) ictl = d & 16'hcf00;
    if (rg == REG_AUX2) aux2 = d & AUX2_WR_MASK;
  endtask : wr

  task automatic rd_chk(input logic [4:0] rg, input logic [15:0] m);
    logic [15:0] e;
    e = rg == REG_SUMMARY ? exp_sum() : rg == REG_IRQ ? (ictl | {12'h0, iflags}) : rg == REG_AUX2 ? aux2 : 16'h0;
    u_sta.frame(PHY, rg, 1'b0, 16'h0, rd);
    check(rd, e, m);
    check({15'h0, u_sta.ta_level}, 16'h0, 16'h1);
    // a read clears latched bits and reloads the link bit
    if (rg == REG_SUMMARY) begin
      hi_sum = 16'h0;
      lo_link = line_stat.link_pass;
    end
    if (rg == REG_IRQ) iflags = 4'h0;
  endtask : rd_chk

  task automatic line_flip(input int idx);
    @(negedge core_clk);
    line_stat[idx] = !line_stat[idx];
    if (!line_stat.link_pass) lo_link = 1'b0;
    if (!ictl[INT_MASK_LO + 1 + idx]) iflags[idx + 1] = 1'b1;
    if (ictl[INT_ENABLE] && !ictl[INT_MASK_LO] && |iflags[3:1]) iflags[0] = 1'b1;
    pin_chk();
  endtask : line_flip

  task automatic pulse(input int p);
    int idx;
    idx = p == 0 ? 0 : p - 3;
    @(negedge core_clk);
    an_stat[idx] = 1'b1;
    hi_sum[p] = 1'b1;
    @(negedge core_clk);
    an_stat[idx] = 1'b0;
  endtask : pulse

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_fail++;
      $display("[ERR] %0t run did not finish", $time);
      summarize();
    end
  end

  initial begin
    repeat (8) @(negedge core_clk);
    reset = 1'b0;
    @(negedge core_clk);
    check({11'h0, mode_cfg}, 16'h0003, 16'hffff);
    rd_chk(REG_SUMMARY, 16'hffff);
    rd_chk(REG_IRQ, 16'hffff);
    rd_chk(REG_AUX2, 16'hffff);
    for (int k = 0; k < 6; k++) begin
      lfsr = lfsr_step(lfsr);
      @(negedge core_clk);
      an_stat.resolved_best_mode = 3'(k);
      an_stat.an_done = lfsr[0];
      an_stat.pause = lfsr[1];
      an_stat.remote_fault = lfsr[2];
      an_stat.partner_an_able = lfsr[3];
      an_ctrl_en = lfsr[4];
      pulse(hi_pos[k]);
      rd_chk(REG_SUMMARY, 16'hffff);
    end
    rd_chk(REG_SUMMARY, 16'hffff);
    line_flip(0);
    line_flip(0);
    rd_chk(REG_SUMMARY, 16'hffff);
    rd_chk(REG_SUMMARY, 16'hffff);
    for (int i = 0; i < 3; i++) begin
      wr(REG_IRQ, 16'h4e00 & ~(16'h0200 << i));
      line_flip(i);
      line_flip((i + 1) % 3);
      line_flip(i);
      rd_chk(REG_IRQ, 16'hffff);
      pin_chk();
    end
    wr(REG_IRQ, 16'h4100);
    line_flip(2);
    rd_chk(REG_IRQ, 16'hffff);
    wr(REG_IRQ, 16'hb000);
    line_flip(1);
    rd_chk(REG_IRQ, 16'hffff);
    wr(REG_IRQ, 16'h4000);
    line_flip(2);
    wr(REG_IRQ, 16'h0000);
    pin_chk();
    rd_chk(REG_IRQ, 16'hffff);
    for (int j = 0; j < 3; j++) begin
      lfsr = lfsr_step(lfsr);
      wr(REG_AUX2, aux_set[j] | (j == 2 ? lfsr[15:0] & 16'h0d82 : 16'h0));
      @(negedge core_clk);
      check({11'h0, mode_cfg}, {11'h0, aux2[11], aux2[10], aux2[8], aux2[7], aux2[1]}, 16'hffff);
      rd_chk(REG_AUX2, 16'hffff);
      line_stat = 3'b001;
      rx_bit_len = lfsr[31:16];
      tx_en = 1'b1;
      // receive path quiet so that only the echo can reach rx_dv
      rx_dv_raw = 1'b0;
      pd_in = 4'h0;
      repeat (2) @(negedge core_clk);
      check(rx_nibble_len, aux2[11] ? rx_bit_len & 16'hfffc : rx_bit_len, 16'hffff);
      check({14'h0, rx_dv, crs}, {14'h0, !aux2[7], 1'b1}, 16'h3);
      tx_en = 1'b0;
      rx_dv_raw = 1'b1;
      repeat (2) @(negedge core_clk);
      check({14'h0, rx_dv, crs}, 16'h0002, 16'h3);
      for (int m = 0; m < 16; m++) begin
        pd_in = 4'(m);
        repeat (2) @(negedge core_clk);
        check({15'h0, link_assert}, {15'h0, pd_in[3] && (!aux2[1] || (pd_in[2] ? pd_in[0] : pd_in[1]))}, 16'h1);
      end
    end
    // slower station, unmapped register and a foreign address
    u_sta.half = 14;
    rd_chk(5'h1c, 16'hffff);
    u_sta.frame(5'h02, REG_AUX2, 1'b1, 16'h0000, rd);
    u_sta.frame(5'h02, REG_AUX2, 1'b0, 16'h0, rd);
    check(rd, 16'hffff, 16'hffff);
    rd_chk(REG_AUX2, 16'hffff);
    summarize();
  end
endmodule : psi_status_regs_tb_top
